/* File: hdl/bscan_test_regs.sv */
/*
  Bypass, identification and boundary scan test data registers.
  Assumes a TAP controller on ref_clk supplies the current instruction and
  one-hot state levels that stay put between test clock edges; the test
  clock and serial input arrive as pins and are oversampled here.
*/
// Behaviour
// - A one-bit bypass stage links serial in to serial out under BYPASS, CLAMP or HIGHZ.
// - The identification register has a 32-stage shift path and a 32-bit latched output.
// - The identification register is selected under IDCODE and in Test-Logic-Reset.
// - The chain holds cells 0 to 45, cell 0 bus bit one, cell 45 bus bit two.
// - Bus bits one to seven take their enable from control cell 1.
// - Bus bit zero at cell 2 takes its enable from control cell 3.
// - The interrupt output at cell 14 is tri-state, enabled by cell 15.
// - The transmit sync output at cell 25 is tri-state, enabled by cell 26.
// - All other cells, except 40 to 44 for bus bits seven to three, only observe their pin and never drive it.
// - Codes 111, 011, 100 pick bypass, 001 picks identification, 000 and 010 the chain.
// - The captured identification has bit 0 set, then 11 maker, 16 part, 4 version bits.
`timescale 1ns/1ps
module bscan_test_regs
  import bscan_pkg::*;
#(
  // Arbitrary identification values, no meaning attached
  parameter logic [10:0] MFR_CODE = 11'h155,
  parameter logic [15:0] PART_CODE = 16'hA5C3,
  parameter logic [3:0] VERSION_CODE = 4'h1
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic test_clock,
  input wire logic test_serial_in,
  input wire logic [IR_W-1:0] instruction,
  input wire logic tap_reset_state,
  input wire logic capture_dr,
  input wire logic shift_dr,
  input wire logic update_dr,
  input wire logic [CHAIN_LEN-1:0] pin_sense,
  input wire logic [BUS_W-1:0] core_bus_out,
  input wire logic core_bus_upper_oe,
  input wire logic core_bus0_oe,
  input wire logic core_irq_out,
  input wire logic core_irq_oe,
  input wire logic core_tx_sync,
  input wire logic core_tx_sync_oe,
  output logic test_serial_out,
  output logic [BUS_W-1:0] bus_out,
  output logic [BUS_W-1:0] bus_oe,
  output logic irq_out,
  output logic irq_oe,
  output logic tx_sync_8k_output,
  output logic tx_sync_oe,
  output logic [ID_LEN-1:0] id_parallel
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling

  logic [1:0] tpin_level;
  logic tck_rise;
  logic tck_fall;
  logic [CHAIN_LEN-1:0] sense_meta_r;
  logic [CHAIN_LEN-1:0] sense_r;

  pin_sync #(.WIDTH(2)) u_tsync (
    .ref_clk(ref_clk),
    .reset(reset),
    .pin_in({test_serial_in, test_clock}),
    .level(tpin_level),
    .rise(tck_rise),
    .fall(tck_fall)
  );

  wire tdi_s = tpin_level[1];

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sense_meta_r <= CHAIN_RESET;
      sense_r <= CHAIN_RESET;
    end else begin
      sense_meta_r <= pin_sense;
      sense_r <= sense_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register selection

  function automatic sel_type decode_sel(input logic [IR_W-1:0] ins,
                                         input logic tlr);
    if (tlr) begin
      decode_sel = SEL_ID;
    end else begin
      case (ins)
        INS_IDCODE: decode_sel = SEL_ID;
        INS_EXTEST: decode_sel = SEL_CHAIN;
        INS_SAMPLE: decode_sel = SEL_CHAIN;
        INS_BYPASS: decode_sel = SEL_BYPASS;
        INS_CLAMP: decode_sel = SEL_BYPASS;
        INS_HIGHZ: decode_sel = SEL_BYPASS;
        // Unused codes fall back to bypass, the safe short path
        default: decode_sel = SEL_BYPASS;
      endcase
    end
  endfunction

  sel_type sel;
  assign sel = decode_sel(instruction, tap_reset_state);

  wire do_capture = tck_rise & capture_dr;
  wire do_shift = tck_rise & shift_dr;
  wire do_update = tck_fall & update_dr;

  ////////////////////////////////////////////////////////////////////////////
  // Bypass stage

  logic bypass_r;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bypass_r <= 1'b0;
    end else if (sel == SEL_BYPASS && do_capture) begin
      bypass_r <= 1'b0;
    end else if (sel == SEL_BYPASS && do_shift) begin
      bypass_r <= tdi_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Identification register

  logic [ID_LEN-1:0] id_value;
  logic [ID_LEN-1:0] id_shift_r;
  logic [ID_LEN-1:0] id_latch_r;

  always_comb begin
    id_value = ID_RESET;
    id_value[0] = ID_MARKER;
    id_value[ID_MFR_LSB +: ID_MFR_W] = MFR_CODE;
    id_value[ID_PART_LSB +: ID_PART_W] = PART_CODE;
    id_value[ID_VER_LSB +: ID_VER_W] = VERSION_CODE;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      id_shift_r <= ID_RESET;
    end else if (sel == SEL_ID && do_capture) begin
      id_shift_r <= id_value;
    end else if (sel == SEL_ID && do_shift) begin
      id_shift_r <= {tdi_s, id_shift_r[ID_LEN-1:1]};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      id_latch_r <= ID_RESET;
    end else if (sel == SEL_ID && do_update) begin
      id_latch_r <= id_shift_r;
    end
  end

  assign id_parallel = id_latch_r;

  ////////////////////////////////////////////////////////////////////////////
  // Boundary scan chain, serial in at cell 45, out at cell 0

  logic [CHAIN_LEN-1:0] chain_cap;
  logic [CHAIN_LEN-1:0] chain_shift_r;
  logic [CHAIN_LEN-1:0] chain_latch_r;
  logic [BUS_W-1:0] bus_cell;

  // Bus bit n lives at cell 0 (n=1), cell 2 (n=0) or 47-n (n=2..7)
  function automatic int bus_cell_of(input int n);
    if (n == 0) begin
      bus_cell_of = CELL_BUS0;
    end else if (n == 1) begin
      bus_cell_of = CELL_BUS1;
    end else begin
      bus_cell_of = CELL_BUS2 + 2 - n;
    end
  endfunction

  // Observe-only and output cells sample the pin; control cells sample
  // the core enable, since there is no pin behind them
  always_comb begin
    chain_cap = sense_r;
    chain_cap[CELL_BUS_UPPER_EN] = core_bus_upper_oe;
    chain_cap[CELL_BUS0_EN] = core_bus0_oe;
    chain_cap[CELL_IRQ_EN] = core_irq_oe;
    chain_cap[CELL_TX_SYNC_EN] = core_tx_sync_oe;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      chain_shift_r <= CHAIN_RESET;
    end else if (sel == SEL_CHAIN && do_capture) begin
      chain_shift_r <= chain_cap;
    end else if (sel == SEL_CHAIN && do_shift) begin
      chain_shift_r <= {tdi_s, chain_shift_r[CHAIN_LEN-1:1]};
    end
  end

  // Update latch holds during CLAMP so outputs stay still
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      chain_latch_r <= CHAIN_RESET;
    end else if (sel == SEL_CHAIN && do_update) begin
      chain_latch_r <= chain_shift_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive selection

  wire test_drive = ~tap_reset_state &
                    (instruction == INS_EXTEST || instruction == INS_CLAMP);
  wire test_float = ~tap_reset_state & (instruction == INS_HIGHZ);

  wire upper_en = chain_latch_r[CELL_BUS_UPPER_EN] == CTRL_ENABLE;
  wire bus0_en = chain_latch_r[CELL_BUS0_EN] == CTRL_ENABLE;
  wire irq_en = chain_latch_r[CELL_IRQ_EN] == CTRL_ENABLE;
  wire sync_en = chain_latch_r[CELL_TX_SYNC_EN] == CTRL_ENABLE;

  logic [BUS_W-1:0] bus_test_oe;

  genvar gi;
  generate
    for (gi = 0; gi < BUS_W; gi++) begin : g_bus
      assign bus_cell[gi] = chain_latch_r[bus_cell_of(gi)];
      if (gi == 0) begin : g_b0
        assign bus_test_oe[gi] = bus0_en;
      end else begin : g_bn
        assign bus_test_oe[gi] = upper_en;
      end
    end
  endgenerate

  wire [BUS_W-1:0] core_bus_oe = {{(BUS_W-1){core_bus_upper_oe}}, core_bus0_oe};

  logic [BUS_W-1:0] bus_out_nxt;
  logic [BUS_W-1:0] bus_oe_nxt;
  logic irq_nxt;
  logic irq_oe_nxt;
  logic sync_nxt;
  logic sync_oe_nxt;

  assign bus_out_nxt = test_drive ? bus_cell : core_bus_out;
  assign bus_oe_nxt = test_float ? '0 :
                      test_drive ? bus_test_oe : core_bus_oe;
  assign irq_nxt = test_drive ? chain_latch_r[CELL_IRQ] : core_irq_out;
  assign irq_oe_nxt = test_float ? 1'b0 :
                      test_drive ? irq_en : core_irq_oe;
  assign sync_nxt = test_drive ? chain_latch_r[CELL_TX_SYNC] : core_tx_sync;
  assign sync_oe_nxt = test_float ? 1'b0 :
                       test_drive ? sync_en : core_tx_sync_oe;

  logic [BUS_W-1:0] bus_out_r;
  logic [BUS_W-1:0] bus_oe_r;
  logic irq_r;
  logic irq_oe_r;
  logic sync_r;
  logic sync_oe_r;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bus_out_r <= '0;
      bus_oe_r <= '0;
      irq_r <= 1'b0;
      irq_oe_r <= 1'b0;
      sync_r <= 1'b0;
      sync_oe_r <= 1'b0;
    end else begin
      bus_out_r <= bus_out_nxt;
      bus_oe_r <= bus_oe_nxt;
      irq_r <= irq_nxt;
      irq_oe_r <= irq_oe_nxt;
      sync_r <= sync_nxt;
      sync_oe_r <= sync_oe_nxt;
    end
  end

  assign bus_out = bus_out_r;
  assign bus_oe = bus_oe_r;
  assign irq_out = irq_r;
  assign irq_oe = irq_oe_r;
  assign tx_sync_8k_output = sync_r;
  assign tx_sync_oe = sync_oe_r;

  ////////////////////////////////////////////////////////////////////////////
  // Serial out, changes on the falling test clock edge

  logic tdo_r;
  logic tdo_nxt;

  assign tdo_nxt = (sel == SEL_ID) ? id_shift_r[0] :
                   (sel == SEL_CHAIN) ? chain_shift_r[0] : bypass_r;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tdo_r <= 1'b0;
    end else if (tck_fall) begin
      tdo_r <= tdo_nxt;
    end
  end

  assign test_serial_out = tdo_r;

endmodule

/* File: pkg/bscan_pkg.sv */
/*
  Constants for the boundary scan test data registers: instruction codes,
  chain cell positions, identification field layout and reset values.
  Assumes nothing of its surroundings.
*/
package bscan_pkg;

  localparam int IR_W = 3;
  localparam logic [2:0] INS_EXTEST = 3'h0;
  localparam logic [2:0] INS_IDCODE = 3'h1;
  localparam logic [2:0] INS_SAMPLE = 3'h2;
  localparam logic [2:0] INS_CLAMP = 3'h3;
  localparam logic [2:0] INS_HIGHZ = 3'h4;
  localparam logic [2:0] INS_BYPASS = 3'h7;

  localparam int CHAIN_LEN = 46;
  localparam int ID_LEN = 32;
  localparam int BUS_W = 8;

  // Output cells and their enable cells
  localparam int CELL_BUS1 = 0;
  localparam int CELL_BUS_UPPER_EN = 1;
  localparam int CELL_BUS0 = 2;
  localparam int CELL_BUS0_EN = 3;
  localparam int CELL_IRQ = 14;
  localparam int CELL_IRQ_EN = 15;
  localparam int CELL_TX_SYNC = 25;
  localparam int CELL_TX_SYNC_EN = 26;
  localparam int CELL_BUS7 = 40;
  localparam int CELL_BUS2 = 45;

  // Identification field layout
  localparam int ID_MFR_LSB = 1;
  localparam int ID_MFR_W = 11;
  localparam int ID_PART_LSB = 12;
  localparam int ID_PART_W = 16;
  localparam int ID_VER_LSB = 28;
  localparam int ID_VER_W = 4;
  localparam logic ID_MARKER = 1'h1;

  // Control cell value that enables its outputs
  localparam logic CTRL_ENABLE = 1'h1;

  localparam logic [CHAIN_LEN-1:0] CHAIN_RESET = 46'h0;
  localparam logic [ID_LEN-1:0] ID_RESET = 32'h0;

  typedef enum logic [1:0] {
    SEL_BYPASS = 2'h0,
    SEL_ID = 2'h1,
    SEL_CHAIN = 2'h3
  } sel_type;

endpackage

/* File: hdl/pin_sync.sv */
/*
  Two-stage synchroniser for a group of pins, with edge detection on bit 0.
  Assumes the pins are asynchronous to clk; edges are seen two to three
  cycles after they happen at the pin.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 2
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level,
  output logic rise,
  output logic fall
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;
  logic prev_r;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      prev_r <= sync_r[0];
    end
  end

  assign level = sync_r;
  assign rise = sync_r[0] & ~prev_r;
  assign fall = ~sync_r[0] & prev_r;

endmodule

/* File: testbench/bscan_checker_properties.sv */
/*
  Checker for the test data register pins.
  Assumes the ref_clk domain ports of bscan_test_regs only.
*/
`timescale 1ns/1ps
module bscan_checker
  import bscan_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic test_clock,
  input wire logic [IR_W-1:0] instruction,
  input wire logic tap_reset_state,
  input wire logic update_dr,
  input wire logic [BUS_W-1:0] core_bus_out,
  input wire logic core_irq_out,
  input wire logic core_irq_oe,
  input wire logic core_tx_sync_oe,
  input wire logic test_serial_out,
  input wire logic [BUS_W-1:0] bus_out,
  input wire logic [BUS_W-1:0] bus_oe,
  input wire logic irq_out,
  input wire logic irq_oe,
  input wire logic tx_sync_8k_output,
  input wire logic tx_sync_oe,
  input wire logic [ID_LEN-1:0] id_parallel
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence tlr_now;
    tap_reset_state && !$past(reset);
  endsequence
  // Three cycles so the outputs already came from the latch
  sequence clamp_steady;
    (instruction == INS_CLAMP && !update_dr && !tap_reset_state) [*3];
  endsequence
  AST_FUNC_BUS: assert property (
    tlr_now |=> bus_out == $past(core_bus_out))
    else $error("bus not functional in reset state");
  AST_FUNC_IRQ_SYNC: assert property (
    tlr_now |=> irq_out == $past(core_irq_out) && irq_oe == $past(core_irq_oe)
      && tx_sync_oe == $past(core_tx_sync_oe))
    else $error("irq or sync not functional");
  AST_BUS_SHARED_EN: assert property (
    bus_oe[7:1] == 7'h00 || bus_oe[7:1] == 7'h7F)
    else $error("upper bus enables differ");
  AST_HIGHZ_OFF: assert property (
    instruction == INS_HIGHZ && !tap_reset_state
      |=> {bus_oe, irq_oe, tx_sync_oe} == 10'h000)
    else $error("output enabled under highz");
  AST_CLAMP_HOLD: assert property (
    clamp_steady |-> $stable(bus_out) && $stable(bus_oe) && $stable(irq_out)
      && $stable(tx_sync_8k_output))
    else $error("outputs moved under clamp");
  AST_TDO_AFTER_FALL: assert property (
    $changed(test_serial_out) |-> !$past(test_clock, 2)
      && !$past(test_clock, 3))
    else $error("serial out changed without a fall");
  AST_ID_LATCH: assert property (
    $changed(id_parallel) |-> $past(update_dr) || $past(tap_reset_state))
    else $error("id latch changed outside update");
  AST_IDLE_AFTER_RESET: assert property (
    $fell(reset) |-> {bus_oe, irq_oe, tx_sync_oe} == 10'h000)
    else $error("output enabled after reset");
endmodule
bind bscan_test_regs bscan_checker u_chk (.*);

/* File: testbench/jtag_host_model.sv */
/*
  Test controller model: makes test clock, serial data and TAP levels.
  Assumes ref_clk only for pacing; test clock stands low between scans.
*/
`timescale 1ns/1ps
module jtag_host_model
  import bscan_pkg::*;
(
  input wire logic ref_clk,
  input wire logic test_serial_out,
  output logic test_clock,
  output logic test_serial_in,
  output logic [IR_W-1:0] instruction,
  output logic tap_reset_state,
  output logic capture_dr,
  output logic shift_dr,
  output logic update_dr
);
  initial begin
    {test_clock, test_serial_in, capture_dr, shift_dr, update_dr} = 5'h00;
    instruction = INS_BYPASS;
    tap_reset_state = 1'b1;
  end
  // 160 ns period; levels move only 3 cycles after a fall
  task automatic pulse(output logic s);
    @(negedge ref_clk) test_clock = 1'b1;
    repeat (4) @(negedge ref_clk);
    s = test_serial_out;
    test_clock = 1'b0;
    repeat (3) @(negedge ref_clk);
  endtask
  task automatic setup(input logic [2:0] ins, input logic tlr);
    @(negedge ref_clk) instruction = ins;
    tap_reset_state = tlr;
  endtask
  task automatic scan(input logic [2:0] ins, input int n,
      input logic [63:0] din, output logic [63:0] dout,
      input logic tlr = 1'b0);
    logic s;
    dout = 64'h0;
    // Reset state selects the identification register whatever the code
    setup(ins, tlr);
    capture_dr = 1'b1;
    pulse(s);
    {capture_dr, shift_dr} = 2'h1;
    for (int i = 0; i < n; i++) begin
      test_serial_in = din[i];
      pulse(dout[i]);
    end
    // Released line shows the inverse, not the last bit
    test_serial_in = ~test_serial_in;
    {shift_dr, update_dr} = 2'h1;
    pulse(s);
    update_dr = 1'b0;
  endtask
endmodule

/* File: testbench/test_boundary_scan_test_registers.sv */
/*
  Self-checking bench for the test data registers.
  Assumes jtag_host_model on the far side and the bound checker.
*/
`timescale 1ns/1ps
module test_boundary_scan_test_registers;
  import bscan_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic test_clock, test_serial_in, tap_reset_state;
  logic capture_dr, shift_dr, update_dr, test_serial_out;
  logic [IR_W-1:0] instruction;
  logic [CHAIN_LEN-1:0] pin_sense = 46'h0;
  logic [BUS_W-1:0] core_bus_out = 8'h00;
  logic core_bus_upper_oe = 1'b0, core_bus0_oe = 1'b0, core_irq_out = 1'b0;
  logic core_irq_oe = 1'b0, core_tx_sync = 1'b0, core_tx_sync_oe = 1'b0;
  logic [BUS_W-1:0] bus_out, bus_oe;
  logic irq_out, irq_oe, tx_sync_8k_output, tx_sync_oe;
  logic [ID_LEN-1:0] id_parallel;
  logic [63:0] exp_q[$], obs_q[$], din, dout, cap;
  string nm_q[$];
  int miscompares = 0;
  int tests_run = 0;
  logic [2:0] byp[3] = '{INS_BYPASS, INS_CLAMP, INS_HIGHZ};
  always #10 ref_clk = ~ref_clk;
  // Identification values are arbitrary
  bscan_test_regs #(.MFR_CODE(11'h2AB), .PART_CODE(16'h5A3C),
    .VERSION_CODE(4'h9)) u_dut (.*);
  jtag_host_model u_host (.*);
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [63:0] s, e);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic note(input string nm, input logic [63:0] e, s);
    nm_q.push_back(nm);
    exp_q.push_back(e);
    obs_q.push_back(s);
  endtask
  always @(posedge ref_clk) begin
    if (obs_q.size() > 0) check(nm_q.pop_front(), obs_q.pop_front(),
      exp_q.pop_front());
  end
  function automatic logic [63:0] pins();
    return {bus_out, bus_oe, irq_out, irq_oe, tx_sync_8k_output, tx_sync_oe};
  endfunction
  function automatic logic [63:0] latch_pins(input logic [45:0] d);
    return {d[40], d[41], d[42], d[43], d[44], d[45], d[0], d[2],
      {7{d[1]}}, d[3], d[14], d[15], d[25], d[26]};
  endfunction
  task automatic rnd_core();
    @(negedge ref_clk) pin_sense = 46'({$urandom(), $urandom()});
    {core_bus_out, core_bus_upper_oe, core_bus0_oe, core_irq_out,
      core_irq_oe, core_tx_sync, core_tx_sync_oe} = 14'($urandom());
    repeat (4) @(negedge ref_clk);
  endtask
  task automatic stop_test();
    repeat (3) @(posedge ref_clk);
    $display("counts tests_run %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge ref_clk);
    miscompares++;
    stop_test();
  end
  initial begin
    void'($urandom(84));
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk) reset = 1'b0;
    rnd_core();
    note("functional", {core_bus_out, {7{core_bus_upper_oe}}, core_bus0_oe,
      core_irq_out, core_irq_oe, core_tx_sync, core_tx_sync_oe}, pins());
    $display("test functional done");
    din = {$urandom(), $urandom()};
    u_host.scan(INS_IDCODE, 32, din, dout);
    note("idcode", {4'h9, 16'h5A3C, 11'h2AB, 1'b1}, dout[31:0]);
    repeat (3) @(negedge ref_clk);
    note("id latch", din[31:0], id_parallel);
    $display("test idcode done");
    din = {$urandom(), $urandom()};
    u_host.scan(INS_BYPASS, 32, din, dout, 1'b1);
    note("tlr id", {4'h9, 16'h5A3C, 11'h2AB, 1'b1}, dout[31:0]);
    repeat (3) @(negedge ref_clk);
    note("tlr latch", din[31:0], id_parallel);
    $display("test reset state id done");
    foreach (byp[k]) begin
      din = 64'($urandom());
      u_host.scan(byp[k], 8, din, dout);
      note("bypass", {din[6:0], 1'b0}, dout[7:0]);
    end
    $display("test bypass done");
    rnd_core();
    cap = pin_sense;
    {cap[1], cap[3], cap[15], cap[26]} = {core_bus_upper_oe, core_bus0_oe,
      core_irq_oe, core_tx_sync_oe};
    din = {$urandom(), $urandom()};
    u_host.scan(INS_SAMPLE, 46, din, dout);
    note("sample", cap[45:0], dout[45:0]);
    rnd_core();
    u_host.setup(INS_EXTEST, 1'b0);
    repeat (3) @(negedge ref_clk);
    note("extest", latch_pins(din[45:0]), pins());
    u_host.setup(INS_HIGHZ, 1'b0);
    repeat (3) @(negedge ref_clk);
    note("highz", 10'h000, {bus_oe, irq_oe, tx_sync_oe});
    u_host.setup(INS_CLAMP, 1'b0);
    rnd_core();
    note("clamp", latch_pins(din[45:0]), pins());
    $display("test chain done");
    stop_test();
  end
endmodule
